// ---- hdl/pcbh_pkg.sv ----
package pcbh_pkg;

  // ----------------------------------------------------------
  // register map
  // ----------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_XFER_COUNT = 8'h08;
  localparam int CTRL_DMA_EN_BIT = 0;
  localparam int CTRL_TGT_EN_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int TGT_INIT_LAT_CYC = 16;
  localparam int TGT_SUBSEQ_LAT_CYC = 8;
  localparam logic [1:0] DMA_HOLD_BEATS = 2'h2;

  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } pcbh_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } pcbh_axil_rsp_t;

  typedef struct packed {
    logic isRead;
    logic isWrite;
    logic isBar1;
    logic isWide;
  } pcbh_cyc_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'h1,
    T_LAG = 3'h2,
    T_XFER = 3'h4
  } pcbh_tstate_t;

  typedef enum logic [3:0] {
    D_IDLE = 4'h1,
    D_STALL = 4'h2,
    D_RUN = 4'h4,
    D_DRAIN = 4'h8
  } pcbh_dstate_t;

endpackage : pcbh_pkg

// ---- hdl/pcbh_wait_timer.sv ----
`timescale 1ns/1ps
module pcbh_wait_timer #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  input wire logic run,
  // result
  output logic expired
);
  import pcbh_pkg::*;

  logic [WIDTH-1:0] cnt_r;

  assign expired = run && !load && (cnt_r == '0);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= loadValue - WIDTH'(1);
    end else if (run && cnt_r != '0) begin
      cnt_r <= cnt_r - WIDTH'(1);
    end
  end

endmodule : pcbh_wait_timer

// ---- hdl/pcbh_axil_slave.sv ----
`timescale 1ns/1ps
module pcbh_axil_slave (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register bus
  input pcbh_pkg::pcbh_axil_req_t axilReq,
  output pcbh_pkg::pcbh_axil_rsp_t axilRsp,
  // register contents
  output logic [31:0] ctrl,
  input wire logic [31:0] statusWord,
  input wire logic [31:0] countWord
);
  import pcbh_pkg::*;

  logic awHeld_r, wHeld_r, awRdy_r, wRdy_r, bValid_r, arRdy_r, rValid_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r, ctrl_r, rData_r;
  logic [3:0] wStrb_r;
  logic [1:0] bResp_r, rResp_r;

  // ----------------------------------------------------------
  // handshake decode
  // ----------------------------------------------------------
  wire awTake = axilReq.awvalid && awRdy_r;
  wire wTake = axilReq.wvalid && wRdy_r;
  wire doWrite = awHeld_r && wHeld_r && !bValid_r;
  wire bValidNxt = doWrite || (bValid_r && !axilReq.bready);
  wire awHeldNxt = (awHeld_r || awTake) && !doWrite;
  wire wHeldNxt = (wHeld_r || wTake) && !doWrite;
  wire arTake = axilReq.arvalid && arRdy_r;
  wire rValidNxt = arTake || (rValid_r && !axilReq.rready);
  wire wrCtrl = doWrite && (awAddr_r == REG_CTRL);
  wire wrMapped = (awAddr_r == REG_CTRL) || (awAddr_r == REG_STATUS)
    || (awAddr_r == REG_XFER_COUNT);
  wire rdCtrl = axilReq.araddr == REG_CTRL;
  wire rdStatus = axilReq.araddr == REG_STATUS;
  wire rdCount = axilReq.araddr == REG_XFER_COUNT;
  wire rdMapped = rdCtrl || rdStatus || rdCount;
  wire [31:0] rdWord = rdCtrl ? ctrl_r : rdStatus ? statusWord : rdCount ? countWord : '0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awRdy_r <= 1'b0;
      wRdy_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end else begin
      awHeld_r <= awHeldNxt;
      wHeld_r <= wHeldNxt;
      awRdy_r <= !awHeldNxt && !bValidNxt;
      wRdy_r <= !wHeldNxt && !bValidNxt;
      bValid_r <= bValidNxt;
      if (doWrite) bResp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clk) begin
    if (awTake) awAddr_r <= axilReq.awaddr;
    if (wTake) wData_r <= axilReq.wdata;
    if (wTake) wStrb_r <= axilReq.wstrb;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arRdy_r <= 1'b0;
      rValid_r <= 1'b0;
      rData_r <= '0;
      rResp_r <= RESP_OKAY;
    end else begin
      arRdy_r <= !rValidNxt;
      rValid_r <= rValidNxt;
      if (arTake) rData_r <= rdWord;
      if (arTake) rResp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------
  // control register, per byte lane
  // ----------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : gLane
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        ctrl_r[8*i+:8] <= CTRL_RESET[8*i+:8];
      end else if (wrCtrl && wStrb_r[i]) begin
        ctrl_r[8*i+:8] <= wData_r[8*i+:8] & CTRL_MASK[8*i+:8];
      end
    end
  end

  assign ctrl = ctrl_r;
  assign axilRsp = '{awready: awRdy_r, wready: wRdy_r, bresp: bResp_r, bvalid: bValid_r,
    arready: arRdy_r, rdata: rData_r, rresp: rResp_r, rvalid: rValid_r};

endmodule : pcbh_axil_slave

// ---- hdl/pcbh_core.sv ----
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module pcbh_core (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register bus
  input pcbh_pkg::pcbh_axil_req_t axilReq,
  output pcbh_pkg::pcbh_axil_rsp_t axilRsp,
  // pci target side
  input wire logic tgtHit,
  input pcbh_pkg::pcbh_cyc_t tgtCyc,
  input wire logic [7:0] tgtByteEn,
  input wire logic irdyN,
  input wire logic tgtLastPhase,
  output logic termRetry,
  output logic termDisconnect,
  output logic termAbort,
  // pci master and dma side
  input wire logic pciGnt,
  input wire logic dmaRequest,
  input pcbh_pkg::pcbh_cyc_t dmaCyc,
  input wire logic masterBeat,
  input wire logic masterDone,
  output logic frameGo,
  output logic dmaStopReq,
  output logic dmaAbort,
  // backend inputs
  input wire logic backendSinkReady,
  input wire logic backendSourceReady,
  input wire logic [2:0] dataLagCount,
  input wire logic backendOwnershipRequest,
  input wire logic dmaHoldOff,
  input wire logic dmaStall,
  input wire logic backendError,
  // backend outputs
  output logic transferBeginPulse,
  output logic transferEndPulse,
  output pcbh_pkg::pcbh_cyc_t cycQual,
  output logic [3:0] writeLaneStrobeLow,
  output logic [3:0] writeLaneStrobeHigh,
  output logic readLaneStrobe,
  output logic addrAdvance,
  output logic backendOwnershipGrant,
  output logic dmaOwnership
);
  import pcbh_pkg::*;

  localparam int TMR_W = 5;

  pcbh_tstate_t tState_r, tNxt;
  pcbh_dstate_t dState_r, dNxt;
  pcbh_cyc_t cyc_r, cycNxt;
  logic [2:0] lagCnt_r, lagNxt;
  logic [1:0] drainCnt_r, drainNxt;
  logic [31:0] ctrl, xferCount_r;
  logic tmrExpired;
  logic transferBeginPulse_r, transferEndPulse_r, termRetry_r, termDisconnect_r;
  logic termAbort_r, dmaAbort_r, dmaStopReq_r, frameGo_r, dmaOwn_r, grant_r;
  logic readLaneStrobe_r, addrAdvance_r;
  logic [3:0] wrStrobeLow_r, wrStrobeHigh_r;

  // ----------------------------------------------------------
  // target decode
  // ----------------------------------------------------------
  wire irdy = !irdyN;
  wire tIdle = tState_r == T_IDLE;
  wire tActive = !tIdle;
  wire dIdle = dState_r == D_IDLE;
  wire tgtEn = ctrl[CTRL_TGT_EN_BIT];
  wire dmaEn = ctrl[CTRL_DMA_EN_BIT];
  wire wrBeat = tActive && cyc_r.isWrite && backendSinkReady && irdy;
  wire rdBeat = tActive && cyc_r.isRead && backendSourceReady && irdy;
  wire beat = wrBeat || rdBeat;
  wire tgtRefuse = tgtHit && tIdle && (grant_r || !tgtEn || !dIdle);
  wire tStart = tgtHit && tIdle && !tgtRefuse;
  wire tgtErr = tActive && backendError;
  wire tEnd = (tState_r == T_XFER) && beat && tgtLastPhase && !tgtErr;
  wire tDisc = tmrExpired && !beat && !tgtErr;
  wire [TMR_W-1:0] tmrLoadVal = tStart ? TMR_W'(TGT_INIT_LAT_CYC) : TMR_W'(TGT_SUBSEQ_LAT_CYC);

  pcbh_wait_timer #(
    .WIDTH(TMR_W)
  ) uWaitTimer (
    .clk(clk),
    .reset(reset),
    .load(tStart || beat),
    .loadValue(tmrLoadVal),
    .run(tActive),
    .expired(tmrExpired)
  );

  always_comb begin
    tNxt = tState_r;
    lagNxt = lagCnt_r;
    unique case (tState_r)
      T_IDLE: if (tStart) begin
        tNxt = (dataLagCount != 3'h0) ? T_LAG : T_XFER;
        lagNxt = dataLagCount;
      end
      T_LAG: if (tgtErr || tDisc) begin
        tNxt = T_IDLE;
      end else if (beat) begin
        lagNxt = lagCnt_r - 3'h1;
        if (lagCnt_r == 3'h1) tNxt = T_XFER;
      end
      T_XFER: if (tgtErr || tDisc || tEnd) tNxt = T_IDLE;
      default: tNxt = T_IDLE;
    endcase
  end

  // ----------------------------------------------------------
  // dma sequencing
  // ----------------------------------------------------------
  wire dStart = dIdle && dmaRequest && dmaEn && !dmaHoldOff && !grant_r
    && tIdle && !tgtHit;
  wire dAbort = (dState_r == D_STALL) && !pciGnt;
  wire dBusy = (dState_r == D_RUN) || (dState_r == D_DRAIN);
  wire dEnd = dBusy && (dNxt == D_IDLE);

  always_comb begin
    dNxt = dState_r;
    drainNxt = drainCnt_r;
    unique case (dState_r)
      D_IDLE: if (dStart) dNxt = dmaStall ? D_STALL : D_RUN;
      D_STALL: if (!pciGnt) begin
        dNxt = D_IDLE;
      end else if (!dmaStall) begin
        dNxt = D_RUN;
      end
      D_RUN: if (masterDone) begin
        dNxt = D_IDLE;
      end else if (dmaHoldOff) begin
        dNxt = D_DRAIN;
        drainNxt = DMA_HOLD_BEATS;
      end
      D_DRAIN: if (masterDone || (masterBeat && drainCnt_r == 2'h1)) begin
        dNxt = D_IDLE;
      end else if (masterBeat) begin
        drainNxt = drainCnt_r - 2'h1;
      end
      default: dNxt = D_IDLE;
    endcase
  end

  // ----------------------------------------------------------
  // ownership and qualifiers
  // ----------------------------------------------------------
  wire grantNxt = grant_r ? backendOwnershipRequest
    : (backendOwnershipRequest && tIdle && dIdle && !tgtHit && !dStart);
  wire cycClr = transferEndPulse_r || termDisconnect_r || termAbort_r || dmaAbort_r;

  always_comb begin
    cycNxt = cyc_r;
    if (tStart) cycNxt = tgtCyc;
    else if (dStart) cycNxt = dmaCyc;
    else if (cycClr) cycNxt = '0;
  end

  // ----------------------------------------------------------
  // state registers
  // ----------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tState_r <= T_IDLE;
      dState_r <= D_IDLE;
      lagCnt_r <= 3'h0;
      drainCnt_r <= 2'h0;
      cyc_r <= '0;
      grant_r <= 1'b0;
    end else begin
      tState_r <= tNxt;
      dState_r <= dNxt;
      lagCnt_r <= lagNxt;
      drainCnt_r <= drainNxt;
      cyc_r <= cycNxt;
      grant_r <= grantNxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      transferBeginPulse_r <= 1'b0;
      transferEndPulse_r <= 1'b0;
      termRetry_r <= 1'b0;
      termDisconnect_r <= 1'b0;
      termAbort_r <= 1'b0;
      dmaAbort_r <= 1'b0;
    end else begin
      transferBeginPulse_r <= tStart || dStart;
      transferEndPulse_r <= tEnd || dEnd;
      termRetry_r <= tgtRefuse;
      termDisconnect_r <= tDisc;
      termAbort_r <= tgtErr;
      dmaAbort_r <= dAbort;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dmaStopReq_r <= 1'b0;
      frameGo_r <= 1'b0;
      dmaOwn_r <= 1'b0;
      xferCount_r <= '0;
    end else begin
      dmaStopReq_r <= dNxt == D_DRAIN;
      frameGo_r <= (dNxt == D_RUN) || (dNxt == D_DRAIN);
      dmaOwn_r <= dNxt != D_IDLE;
      if (transferEndPulse_r) xferCount_r <= xferCount_r + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrStrobeLow_r <= 4'h0;
      wrStrobeHigh_r <= 4'h0;
      readLaneStrobe_r <= 1'b0;
      addrAdvance_r <= 1'b0;
    end else begin
      wrStrobeLow_r <= wrBeat ? tgtByteEn[3:0] : 4'h0;
      wrStrobeHigh_r <= (wrBeat && cyc_r.isWide) ? tgtByteEn[7:4] : 4'h0;
      readLaneStrobe_r <= rdBeat;
      addrAdvance_r <= beat;
    end
  end

  // ----------------------------------------------------------
  // register bus
  // ----------------------------------------------------------
  pcbh_axil_slave uRegs (
    .clk(clk),
    .reset(reset),
    .axilReq(axilReq),
    .axilRsp(axilRsp),
    .ctrl(ctrl),
    .statusWord({16'h0000, cyc_r, dState_r, tState_r, lagCnt_r, dmaOwn_r, grant_r}),
    .countWord(xferCount_r)
  );

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign termRetry = termRetry_r;
  assign termDisconnect = termDisconnect_r;
  assign termAbort = termAbort_r;
  assign frameGo = frameGo_r;
  assign dmaStopReq = dmaStopReq_r;
  assign dmaAbort = dmaAbort_r;
  assign transferBeginPulse = transferBeginPulse_r;
  assign transferEndPulse = transferEndPulse_r;
  assign cycQual = cyc_r;
  assign writeLaneStrobeLow = wrStrobeLow_r;
  assign writeLaneStrobeHigh = wrStrobeHigh_r;
  assign readLaneStrobe = readLaneStrobe_r;
  assign addrAdvance = addrAdvance_r;
  assign backendOwnershipGrant = grant_r;
  assign dmaOwnership = dmaOwn_r;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  localparam int A_MAX_WAIT = TGT_INIT_LAT_CYC;
  logic [5:0] noBeatCnt_a;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) noBeatCnt_a <= 6'h0;
    else if (!tActive || beat) noBeatCnt_a <= 6'h0;
    else noBeatCnt_a <= noBeatCnt_a + 6'h1;
  end

  sequence sStalled;
    dState_r == D_STALL && dmaStall && pciGnt;
  endsequence

  sequence sGntAbort;
    dmaAbort_r && dState_r == D_IDLE && !transferEndPulse_r;
  endsequence

  a_qual_valid: assert property (
    transferBeginPulse_r |-> cyc_r != '0)
    else $error("qualifiers not valid with begin pulse");
  a_qual_hold: assert property (
    (cyc_r != '0 && !cycClr) |=> $stable(cyc_r))
    else $error("qualifiers changed before end");
  a_wr_strobe: assert property (
    (wrStrobeLow_r != 4'h0) |-> $past(backendSinkReady && !irdyN))
    else $error("write strobe without sink ready and irdy");
  a_strobe_lanes: assert property (
    (wrStrobeLow_r != 4'h0) |-> wrStrobeLow_r == $past(tgtByteEn[3:0]))
    else $error("write strobe lanes mismatched");
  a_wait_limit: assert property (
    noBeatCnt_a <= A_MAX_WAIT)
    else $error("target waited past latency limit");
  a_lag_entry: assert property (
    (tState_r == T_IDLE && tStart && dataLagCount != 3'h0) |=> tState_r == T_LAG)
    else $error("lag count not honoured");
  a_retry_grant: assert property (
    (grant_r && tgtHit) |=> termRetry_r && !transferBeginPulse_r)
    else $error("access during grant not retried");
  a_grant_wait: assert property (
    $rose(grant_r) |-> $past(tIdle && dIdle))
    else $error("grant given during a cycle");
  a_grant_hold: assert property (
    (grant_r && backendOwnershipRequest) |=> grant_r)
    else $error("grant dropped while requested");
  a_dma_own: assert property (
    dmaOwn_r == (dState_r != D_IDLE))
    else $error("dma ownership mismatch");
  a_hold_start: assert property (
    (dIdle && dmaHoldOff) |=> dState_r == D_IDLE && !dmaOwn_r)
    else $error("dma started under hold-off");
  a_hold_drain: assert property (
    (dState_r == D_DRAIN && masterBeat && drainCnt_r == 2'h1) |=> dState_r == D_IDLE)
    else $error("dma not stopped within two transfers");
  a_stall_frame: assert property (
    sStalled |=> !frameGo_r)
    else $error("frame asserted while stalled");
  a_gnt_abort: assert property (
    (dState_r == D_STALL && !pciGnt) |=> sGntAbort)
    else $error("stalled dma not aborted on grant loss");
  a_err_abort: assert property (
    (tActive && backendError) |=> termAbort_r && tState_r == T_IDLE)
    else $error("backend error did not abort target");
  a_err_master: assert property (
    (tIdle && !tStart && backendError) |=> !termAbort_r)
    else $error("backend error acted on master cycle");
  a_begin_pulse: assert property (
    transferBeginPulse_r |=> !transferBeginPulse_r)
    else $error("begin pulse longer than one cycle");
  a_end_pulse: assert property (
    transferEndPulse_r |-> cyc_r != '0 ##1 !transferEndPulse_r)
    else $error("end pulse malformed");

endmodule : pcbh_core

// ---- testbench/pcbh_backend_model.sv ----
`timescale 1ns/1ps
module pcbh_backend_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bench commands
  input wire logic holdReady,
  input wire logic wantOwn,
  // backend drive
  output logic sinkReady,
  output logic sourceReady,
  output logic ownReq
);
  // ----------------------------------------
  // registered backend drive
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sinkReady <= 1'b0;
      sourceReady <= 1'b0;
      ownReq <= 1'b0;
    end else begin
      sinkReady <= !holdReady;
      sourceReady <= !holdReady;
      ownReq <= wantOwn;
    end
  end
endmodule : pcbh_backend_model

// ---- testbench/pcbh_core_test.sv ----
`timescale 1ns/1ps
module pcbh_core_test;
  import pcbh_pkg::*;
  logic clk = 0;
  logic reset = 1;
  pcbh_axil_req_t rq = '0;
  pcbh_axil_rsp_t rs;
  logic tgtHit = 0, irdyN = 1, lastPh = 0, pciGnt = 1, dmaReq = 0, mBeat = 0;
  logic hold = 0, want = 0, holdOff = 0, stall = 0, err = 0;
  pcbh_cyc_t tCyc = '0;
  logic [7:0] be = '0;
  logic [2:0] lag = '0;
  logic sinkRdy, srcRdy, ownReq, retry, disc, abrt, frameGo, stopReq, dAbort;
  logic beginP, endP, rdStb, addrAdv, grant, dmaOwn, b;
  logic [3:0] stbLo, stbHi, ev;
  logic [31:0] d;
  logic [1:0] r;
  pcbh_cyc_t q, q1;
  int numErrors = 0, checkCount = 0, nAb = 0, nDAb = 0, nEnd = 0, n;

  pcbh_core u_dut (.clk(clk), .reset(reset), .axilReq(rq), .axilRsp(rs),
    .tgtHit(tgtHit), .tgtCyc(tCyc), .tgtByteEn(be), .irdyN(irdyN),
    .tgtLastPhase(lastPh), .termRetry(retry), .termDisconnect(disc),
    .termAbort(abrt), .pciGnt(pciGnt), .dmaRequest(dmaReq), .dmaCyc(4'h8),
    .masterBeat(mBeat), .masterDone(1'b0), .frameGo(frameGo),
    .dmaStopReq(stopReq), .dmaAbort(dAbort), .backendSinkReady(sinkRdy),
    .backendSourceReady(srcRdy), .dataLagCount(lag),
    .backendOwnershipRequest(ownReq), .dmaHoldOff(holdOff), .dmaStall(stall),
    .backendError(err), .transferBeginPulse(beginP), .transferEndPulse(endP),
    .cycQual(q), .writeLaneStrobeLow(stbLo), .writeLaneStrobeHigh(stbHi),
    .readLaneStrobe(rdStb), .addrAdvance(addrAdv),
    .backendOwnershipGrant(grant), .dmaOwnership(dmaOwn));

  pcbh_backend_model u_model (.clk(clk), .reset(reset), .holdReady(hold),
    .wantOwn(want), .sinkReady(sinkRdy), .sourceReady(srcRdy), .ownReq(ownReq));

  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (endP === 1'b1) nEnd++;
    if (abrt === 1'b1) nAb++;
    if (dAbort === 1'b1) nDAb++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [95:0] got, input logic [95:0] exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task finalReport();
    $display("errors %0d checks %0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finalReport

  task rd(input logic [7:0] a);
    @(posedge clk);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    @(posedge clk);
    while (rs.arready !== 1'b1) @(posedge clk);
    rq.arvalid <= 1'b0;
    while (rs.rvalid !== 1'b1) @(posedge clk);
    d = rs.rdata;
    r = rs.rresp;
    rq.rready <= 1'b0;
  endtask : rd

  task wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    @(posedge clk);
    rq.awaddr <= a;
    rq.wdata <= v;
    rq.wstrb <= 4'hf;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && rs.awready === 1'b1) begin
        rq.awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && rs.wready === 1'b1) begin
        rq.wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    while (rs.bvalid !== 1'b1) @(posedge clk);
    r = rs.bresp;
    rq.bready <= 1'b0;
  endtask : wr

  // one target access; ev = {end, disconnect, abort, retry}
  task runTgt(input pcbh_cyc_t c);
    @(posedge clk);
    tgtHit <= 1'b1;
    tCyc <= c;
    @(posedge clk);
    tgtHit <= 1'b0;
    for (n = 1; n < 40; n++) begin
      #1;
      if (n == 1) begin
        b = beginP;
        q1 = q;
      end
      ev = {endP, disc, abrt, retry};
      if (|ev === 1'b1) break;
      @(posedge clk);
    end
  endtask : runTgt

  initial begin
    #100000;
    numErrors++;
    $display("[ERR] %0t watchdog expired", $time);
    finalReport();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    rd(REG_CTRL);
    chk(d, CTRL_RESET);
    rd(8'h0c);
    chk({d, r}, {32'h0, RESP_SLVERR});
    wr(REG_CTRL, 32'h1);
    chk(r, RESP_OKAY);
    runTgt(4'h4);
    chk({b, ev}, 5'h01);
    wr(REG_CTRL, 32'h3);
    $display("test registers done");
    irdyN <= 1'b0;
    lastPh <= 1'b1;
    be <= 8'h5a;
    runTgt(4'h5);
    chk({n, ev}, {32'd2, 4'h8});
    chk({b, q1, q}, 9'h1_55);
    chk({stbLo, stbHi, addrAdv}, 9'h14b);
    @(posedge clk);
    lag <= 3'h2;
    #1 chk({endP, q}, 5'h0);
    runTgt(4'h4);
    chk({n, ev}, {32'd4, 4'h8});
    @(posedge clk);
    lag <= 3'h0;
    runTgt(4'h8);
    chk({n, ev, rdStb, stbLo}, {32'd2, 4'h8, 5'h10});
    @(posedge clk);
    irdyN <= 1'b1;
    runTgt(4'h4);
    chk({ev, stbLo, n >= 16 && n <= 19}, 9'h081);
    @(posedge clk);
    irdyN <= 1'b0;
    hold <= 1'b1;
    err <= 1'b1;
    runTgt(4'h4);
    chk(ev, 4'h2);
    $display("test target done");
    @(posedge clk);
    err <= 1'b0;
    hold <= 1'b0;
    want <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(grant, 1'b1);
    runTgt(4'h4);
    chk({b, ev}, 5'h01);
    @(posedge clk);
    want <= 1'b0;
    @(posedge clk);
    #1 chk(grant, 1'b1);
    repeat (3) @(posedge clk);
    #1 chk(grant, 1'b0);
    $display("test ownership done");
    @(posedge clk);
    err <= 1'b1;
    holdOff <= 1'b1;
    stall <= 1'b1;
    dmaReq <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(dmaOwn, 1'b0);
    @(posedge clk);
    holdOff <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({dmaOwn, frameGo}, 2'h2);
    @(posedge clk);
    dmaReq <= 1'b0;
    stall <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(frameGo, 1'b1);
    @(posedge clk);
    holdOff <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(stopReq, 1'b1);
    repeat (2) begin
      @(posedge clk);
      mBeat <= 1'b1;
      @(posedge clk);
      mBeat <= 1'b0;
    end
    repeat (2) @(posedge clk);
    #1 chk({dmaOwn, nEnd, nAb}, {1'b0, 32'd4, 32'd1});
    @(posedge clk);
    err <= 1'b0;
    holdOff <= 1'b0;
    stall <= 1'b1;
    dmaReq <= 1'b1;
    repeat (3) @(posedge clk);
    dmaReq <= 1'b0;
    pciGnt <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({nDAb, dmaOwn, frameGo}, {32'd1, 2'h0});
    @(posedge clk);
    pciGnt <= 1'b1;
    stall <= 1'b0;
    rd(REG_XFER_COUNT);
    chk(d, 32'h4);
    $display("test dma done");
    finalReport();
  end
endmodule : pcbh_core_test
